// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  // --------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------
  logic        core_clk;
  logic        nrst;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic [15:0] data_ram_size;
  logic        kprog_en;
  logic [15:0] kdata_end;
  logic [15:0] kprog_len;
  logic        base_over;
  int          errors;
  int          num_checks;
  int          seed;
  logic [15:0] cur;
  logic [31:0] rnd;
  logic [31:0] corner [6];

  kpb_top #(.RAM_AW(16)) kpb_top_inst (
    .core_clk     (core_clk),
    .nrst         (nrst),
    .reg_addr     (reg_addr),
    .reg_wdata    (reg_wdata),
    .reg_wr       (reg_wr),
    .reg_rd       (reg_rd),
    .reg_rdata    (reg_rdata),
    .data_ram_size(data_ram_size),
    .kprog_en     (kprog_en),
    .kdata_end    (kdata_end),
    .kprog_len    (kprog_len),
    .base_over    (base_over)
  );

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  function automatic logic [15:0] base_of(input logic [31:0] w);
    return {w[15:10], 10'h000};
  endfunction : base_of

  function automatic logic [15:0] len_of(input logic [15:0] b, input logic [15:0] s);
    return (b != 16'h0000 && b <= s) ? s - b : 16'h0000;
  endfunction : len_of

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check

  task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr    <= w;
    reg_rd    <= r;
    reg_addr  <= a;
    reg_wdata <= d;
  endtask : op

  task automatic rd_check(input logic [7:0] a, input logic [31:0] exp);
    op(1'b0, 1'b1, a, 32'h0000_0000);
    op(1'b0, 1'b0, 8'h00, 32'h0000_0000);
    #1;
    check(reg_rdata, exp);
  endtask : rd_check

  // Settles two edges so the partition outputs reflect the field
  task automatic wr_settle(input logic [7:0] a, input logic [31:0] d);
    op(1'b1, 1'b0, a, d);
    op(1'b0, 1'b0, 8'h00, 32'h0000_0000);
    op(1'b0, 1'b0, 8'h00, 32'h0000_0000);
    #1;
  endtask : wr_settle

  task automatic part_check(input logic [15:0] b, input logic [15:0] s);
    check({31'h0, kprog_en}, {31'h0, b != 16'h0000});
    check({16'h0, kdata_end}, {16'h0, (b != 16'h0000) ? b : s});
    check({16'h0, kprog_len}, {16'h0, len_of(b, s)});
    check({31'h0, base_over}, {31'h0, b > s});
    rd_check(kpb_pkg::KPB_OFFS, {16'h0000, b});
    rd_check(kpb_pkg::STAT_OFFS, {30'h0, b > s, b != 16'h0000});
  endtask : part_check

  task automatic print_verdict();
    $display("errors %0d, checks %0d", errors, num_checks);
    if (errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict

  // --------------------------------------------------------------
  // Watchdog, generous against about four hundred cycles of work
  // --------------------------------------------------------------
  initial begin
    #80000;
    errors++;
    print_verdict();
  end

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    // Reset by NBA so the flops see its edge at time zero
    nrst          <= 1'b0;
    reg_wr        <= 1'b0;
    reg_rd        <= 1'b0;
    reg_addr      <= 8'h00;
    reg_wdata     <= 32'h0000_0000;
    data_ram_size <= 16'h4000;
    errors     = 0;
    num_checks = 0;
    seed       = 32;
    cur        = 16'h0000;
    corner = '{32'hFFFF_FFFF, 32'h0000_03FF, 32'hFFFF_0000,
               32'h0000_4000, 32'h0000_4400, 32'h0000_FC00};
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    op(1'b0, 1'b0, 8'h00, 32'h0000_0000);
    #1;
    part_check(16'h0000, 16'h4000);
    // Corner values first, then random words and sizes
    for (int i = 0; i < 46; i++) begin
      rnd = $random(seed);
      @(posedge core_clk);
      if (i >= 6) data_ram_size <= rnd[31:16];
      if (i >= 6) rnd = $random(seed);
      else rnd = corner[i];
      wr_settle(kpb_pkg::KPB_OFFS, rnd);
      cur = base_of(rnd);
      part_check(cur, data_ram_size);
    end
    // Writes elsewhere must leave the base untouched
    wr_settle(kpb_pkg::STAT_OFFS, 32'hFFFF_FFFF);
    wr_settle(8'h08, 32'hFFFF_FFFF);
    part_check(cur, data_ram_size);
    rd_check(8'h08, 32'h0000_0000);
    // Read right behind a write sees the new word, then drops
    op(1'b1, 1'b0, kpb_pkg::KPB_OFFS, 32'h0000_0800);
    op(1'b0, 1'b1, kpb_pkg::KPB_OFFS, 32'h0000_0000);
    op(1'b0, 1'b0, 8'h00, 32'h0000_0000);
    #1;
    check(reg_rdata, 32'h0000_0800);
    op(1'b0, 1'b0, 8'h00, 32'h0000_0000);
    #1;
    check(reg_rdata, 32'h0000_0000);
    // Reset in mid run clears the field
    @(posedge core_clk);
    nrst <= 1'b0;
    #1;
    check({31'h0, kprog_en}, 32'h0);
    check({16'h0, kdata_end}, 32'h0);
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    op(1'b0, 1'b0, 8'h00, 32'h0000_0000);
    #1;
    part_check(16'h0000, data_ram_size);
    print_verdict();
  end
endmodule : tb_top

// ==== hw/kpb_field_reg.sv ====
`timescale 1ns/1ps
module kpb_field_reg (
  input  wire logic                          core_clk,
  input  wire logic                          nrst,
  input  wire logic                          wr_en,
  input  wire logic [kpb_pkg::DATA_W-1:0]    wdata,
  output logic      [kpb_pkg::FIELD_W-1:0]   field_q
);

  logic [kpb_pkg::FIELD_W-1:0] field_d;

  // Only bits 15:10 are stored; the rest of the word is dropped
  always_comb begin
    field_d = field_q;
    if (wr_en) begin
      field_d = wdata[kpb_pkg::FIELD_MSB:kpb_pkg::FIELD_LSB];
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      field_q <= kpb_pkg::FIELD_RESET;
    end else begin
      field_q <= field_d;
    end
  end

endmodule : kpb_field_reg

// ==== hw/kpb_part_calc.sv ====
`timescale 1ns/1ps
module kpb_part_calc #(
  parameter int unsigned RAM_AW = kpb_pkg::RAM_AW_DEF
) (
  input  wire logic                          core_clk,
  input  wire logic                          nrst,
  input  wire logic [kpb_pkg::FIELD_W-1:0]   field,
  input  wire logic [RAM_AW-1:0]             data_ram_size,
  output logic                               kprog_en_q,
  output logic      [RAM_AW-1:0]             kdata_end_q,
  output logic      [RAM_AW-1:0]             kprog_len_q,
  output logic                               base_over_q
);

  logic              kprog_en_d;
  logic [RAM_AW-1:0] kdata_end_d;
  logic [RAM_AW-1:0] kprog_len_d;
  logic              base_over_d;
  logic [RAM_AW-1:0] base_bytes;

  always_comb begin
    base_bytes = '0;
    base_bytes[kpb_pkg::FIELD_MSB:kpb_pkg::FIELD_LSB] = field;
    kprog_en_d  = (field != kpb_pkg::FIELD_RESET);
    base_over_d = kprog_en_d && (base_bytes > data_ram_size);
    // Zero base: all RAM is kernel data, no program area
    kdata_end_d = kprog_en_d ? base_bytes : data_ram_size;
    kprog_len_d = '0;
    // An out-of-range base yields an empty program area, not a wrap
    if (kprog_en_d && !base_over_d) begin
      kprog_len_d = data_ram_size - base_bytes;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      kprog_en_q  <= 1'b0;
      kdata_end_q <= '0;
      kprog_len_q <= '0;
      base_over_q <= 1'b0;
    end else begin
      kprog_en_q  <= kprog_en_d;
      kdata_end_q <= kdata_end_d;
      kprog_len_q <= kprog_len_d;
      base_over_q <= base_over_d;
    end
  end

endmodule : kpb_part_calc

// ==== hw/kpb_top.sv ====
// What this block does
// - Bits 15:10 hold writable kernel program base
// - Bits 9:0 always read zero
// - Reset clears the whole register
// - Zero base gives all RAM to kernel data
// - Bits 31:16 unimplemented, read zero
`timescale 1ns/1ps
module kpb_top #(
  parameter int unsigned RAM_AW = kpb_pkg::RAM_AW_DEF
) (
  input  wire logic                          core_clk,
  input  wire logic                          nrst,
  input  wire logic [kpb_pkg::ADDR_W-1:0]    reg_addr,
  input  wire logic [kpb_pkg::DATA_W-1:0]    reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [kpb_pkg::DATA_W-1:0]    reg_rdata,
  input  wire logic [RAM_AW-1:0]             data_ram_size,
  output logic                               kprog_en,
  output logic      [RAM_AW-1:0]             kdata_end,
  output logic      [RAM_AW-1:0]             kprog_len,
  output logic                               base_over
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  // The field must fit inside the RAM offset, the offset in a bus word
  if (RAM_AW < kpb_pkg::FIELD_MSB + 1) begin : g_aw_low
    $error("RAM_AW too small for base field");
  end
  if (RAM_AW > kpb_pkg::DATA_W) begin : g_aw_high
    $error("RAM_AW wider than bus word");
  end

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  function automatic kpb_pkg::kpb_sel_t kpb_decode(input logic [kpb_pkg::ADDR_W-1:0] a);
    kpb_pkg::kpb_sel_t s;
    s = kpb_pkg::KPB_SEL_NONE;
    if (a == kpb_pkg::KPB_OFFS) begin
      s = kpb_pkg::KPB_SEL_BASE;
    end else if (a == kpb_pkg::STAT_OFFS) begin
      s = kpb_pkg::KPB_SEL_STAT;
    end
    return s;
  endfunction : kpb_decode

  kpb_pkg::kpb_sel_t            wr_sel;
  kpb_pkg::kpb_sel_t            rd_sel;
  logic                         base_wr;
  logic [kpb_pkg::FIELD_W-1:0]  field;

  always_comb begin
    wr_sel  = kpb_decode(reg_addr);
    rd_sel  = kpb_decode(reg_addr);
    // Status word is read-only; writes there and elsewhere are dropped
    base_wr = reg_wr && (wr_sel == kpb_pkg::KPB_SEL_BASE);
  end

  // ---------------------------------------------------------------
  // Base register and partition
  // ---------------------------------------------------------------
  kpb_field_reg u_field (
    .core_clk (core_clk),
    .nrst     (nrst),
    .wr_en    (base_wr),
    .wdata    (reg_wdata),
    .field_q  (field)
  );

  // Partition outputs lag a base write by one cycle
  kpb_part_calc #(
    .RAM_AW (RAM_AW)
  ) u_calc (
    .core_clk      (core_clk),
    .nrst          (nrst),
    .field         (field),
    .data_ram_size (data_ram_size),
    .kprog_en_q    (kprog_en),
    .kdata_end_q   (kdata_end),
    .kprog_len_q   (kprog_len),
    .base_over_q   (base_over)
  );

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  logic [kpb_pkg::DATA_W-1:0] base_word;
  logic [kpb_pkg::DATA_W-1:0] stat_word;
  logic [kpb_pkg::DATA_W-1:0] rdata_d;
  logic [kpb_pkg::DATA_W-1:0] rdata_q;

  always_comb begin
    base_word = '0;
    base_word[kpb_pkg::FIELD_MSB:kpb_pkg::FIELD_LSB] = field;
    stat_word = '0;
    stat_word[kpb_pkg::STAT_EN_BIT]  = kprog_en;
    stat_word[kpb_pkg::STAT_OVR_BIT] = base_over;
    rdata_d = '0;
    // Data stand only in the cycle after the strobe; idle bus reads zero
    if (reg_rd) begin
      unique case (rd_sel)
        kpb_pkg::KPB_SEL_BASE: begin
          rdata_d = base_word;
        end
        kpb_pkg::KPB_SEL_STAT: begin
          rdata_d = stat_word;
        end
        kpb_pkg::KPB_SEL_NONE: begin
          rdata_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  localparam logic [kpb_pkg::DATA_W-1:0] FIELD_MASK =
    {{(kpb_pkg::DATA_W-kpb_pkg::FIELD_MSB-1){1'b0}},
     {kpb_pkg::FIELD_W{1'b1}},
     {kpb_pkg::FIELD_LSB{1'b0}}};

  logic [RAM_AW-1:0] chk_base;
  always_comb begin
    chk_base = '0;
    chk_base[kpb_pkg::FIELD_MSB:kpb_pkg::FIELD_LSB] = field;
  end

  a_reset_clears: assert property (
    @(posedge core_clk) !nrst |-> (field == '0) && (reg_rdata == '0) && !kprog_en
  ) else $error("reset did not clear base register");

  a_base_write: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (reg_wr && reg_addr == kpb_pkg::KPB_OFFS)
    |=> field == $past(reg_wdata[kpb_pkg::FIELD_MSB:kpb_pkg::FIELD_LSB])
  ) else $error("base field did not take written value");

  a_low_zero: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (reg_rd && reg_addr == kpb_pkg::KPB_OFFS)
    |=> (reg_rdata[kpb_pkg::FIELD_LSB-1:0] == '0)
        && (reg_rdata[kpb_pkg::FIELD_MSB:kpb_pkg::FIELD_LSB] == $past(field))
  ) else $error("base readback wrong in low bits or field");

  a_upper_zero: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (reg_rd && reg_addr == kpb_pkg::KPB_OFFS)
    |=> (reg_rdata & ~FIELD_MASK) == '0
  ) else $error("base readback upper bits not zero");

  a_hold_value: assert property (
    @(posedge core_clk) disable iff (!nrst)
    !(reg_wr && reg_addr == kpb_pkg::KPB_OFFS) |=> $stable(field)
  ) else $error("base field changed without base write");

  a_zero_all_data: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (field == '0)
    |=> !kprog_en && (kprog_len == '0) && (kdata_end == $past(data_ram_size))
  ) else $error("zero base did not give all RAM to kernel data");

  a_split_point: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (field != '0) && (chk_base <= data_ram_size)
    |=> kprog_en && !base_over && (kdata_end == $past(chk_base))
        && (kprog_len + kdata_end == $past(data_ram_size))
  ) else $error("program area split wrong");

  a_over_flag: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (chk_base > data_ram_size) |=> base_over && (kprog_len == '0)
  ) else $error("base above RAM size not flagged");

  a_rdata_idle: assert property (
    @(posedge core_clk) disable iff (!nrst)
    !reg_rd |=> reg_rdata == '0
  ) else $error("read data present without read strobe");

  // ---------------------------------------------------------------
  // Status and unmapped reads, stray writes
  // ---------------------------------------------------------------
  // Only these status bits may ever read as one
  logic [kpb_pkg::DATA_W-1:0] stat_mask;
  always_comb begin
    stat_mask = '0;
    stat_mask[kpb_pkg::STAT_EN_BIT]  = 1'b1;
    stat_mask[kpb_pkg::STAT_OVR_BIT] = 1'b1;
  end

  a_stat_read: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (reg_rd && reg_addr == kpb_pkg::STAT_OFFS)
    |=> (reg_rdata[kpb_pkg::STAT_EN_BIT] == $past(kprog_en))
        && (reg_rdata[kpb_pkg::STAT_OVR_BIT] == $past(base_over))
  ) else $error("status readback does not match partition");

  a_stat_upper: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (reg_rd && reg_addr == kpb_pkg::STAT_OFFS)
    |=> (reg_rdata & ~stat_mask) == '0
  ) else $error("status readback has stray bits");

  a_unmapped_read: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (reg_rd && (reg_addr != kpb_pkg::KPB_OFFS) && (reg_addr != kpb_pkg::STAT_OFFS))
    |=> reg_rdata == '0
  ) else $error("unmapped read returned data");

  a_other_write: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (reg_wr && reg_addr != kpb_pkg::KPB_OFFS)
    |=> $stable(field)
  ) else $error("write to another address moved the base");

  a_rd_after_wr: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (reg_wr && reg_addr == kpb_pkg::KPB_OFFS)
    ##1 (reg_rd && reg_addr == kpb_pkg::KPB_OFFS)
    |=> reg_rdata[kpb_pkg::FIELD_MSB:kpb_pkg::FIELD_LSB]
        == $past(reg_wdata[kpb_pkg::FIELD_MSB:kpb_pkg::FIELD_LSB], 2)
  ) else $error("read right after write missed the new base");

  // ---------------------------------------------------------------
  // Partition consistency
  // ---------------------------------------------------------------
  a_reset_outputs: assert property (
    @(posedge core_clk)
    !nrst |-> (kdata_end == '0) && (kprog_len == '0) && !base_over
  ) else $error("reset did not clear partition outputs");

  a_en_follows: assert property (
    @(posedge core_clk) disable iff (!nrst)
    kprog_en == ($past(field) != '0)
  ) else $error("program area flag does not follow base field");

  a_zero_no_len: assert property (
    @(posedge core_clk) disable iff (!nrst)
    !kprog_en |-> (kprog_len == '0)
  ) else $error("program length without program area");

  a_over_needs_en: assert property (
    @(posedge core_clk) disable iff (!nrst)
    base_over |-> kprog_en && (kprog_len == '0)
  ) else $error("overflow flag without program area");

  a_base_equal_size: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (field != '0) && (chk_base == data_ram_size)
    |=> !base_over && (kprog_len == '0)
  ) else $error("base equal to size handled wrong");

  // Outputs lag their inputs by one edge, hence the past size
  a_len_in_ram: assert property (
    @(posedge core_clk) disable iff (!nrst)
    kprog_len <= $past(data_ram_size)
  ) else $error("program area longer than data RAM");

  a_end_in_ram: assert property (
    @(posedge core_clk) disable iff (!nrst)
    !base_over |-> (kdata_end <= $past(data_ram_size))
  ) else $error("kernel data end beyond data RAM");

  c_write_nonzero: cover property (
    @(posedge core_clk) disable iff (!nrst)
    (reg_wr && reg_addr == kpb_pkg::KPB_OFFS) ##1 kprog_en
  );

  c_write_then_read: cover property (
    @(posedge core_clk) disable iff (!nrst)
    (reg_wr && reg_addr == kpb_pkg::KPB_OFFS)
    ##1 (reg_rd && reg_addr == kpb_pkg::KPB_OFFS)
  );

  c_base_over: cover property (
    @(posedge core_clk) disable iff (!nrst)
    $rose(base_over)
  );

  c_back_to_zero: cover property (
    @(posedge core_clk) disable iff (!nrst)
    $fell(kprog_en)
  );

  c_stat_read: cover property (
    @(posedge core_clk) disable iff (!nrst)
    (reg_rd && reg_addr == kpb_pkg::STAT_OFFS) ##1 reg_rdata[kpb_pkg::STAT_OVR_BIT]
  );

endmodule : kpb_top

// ==== inc/kpb_pkg.sv ====
package kpb_pkg;

  // ---------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned ADDR_W      = 8;
  localparam logic [7:0]  KPB_OFFS    = 8'h00;
  localparam logic [7:0]  STAT_OFFS   = 8'h04;

  // ---------------------------------------------------------------
  // Kernel program base field
  // ---------------------------------------------------------------
  localparam int unsigned FIELD_LSB   = 10;
  localparam int unsigned FIELD_MSB   = 15;
  localparam int unsigned FIELD_W     = FIELD_MSB - FIELD_LSB + 1;
  localparam logic [5:0]  FIELD_RESET = 6'h00;
  localparam int unsigned RAM_AW_DEF  = 16;

  // ---------------------------------------------------------------
  // Status word layout
  // ---------------------------------------------------------------
  localparam int unsigned STAT_EN_BIT  = 0;
  localparam int unsigned STAT_OVR_BIT = 1;

  typedef enum logic [1:0] {
    KPB_SEL_NONE,
    KPB_SEL_BASE,
    KPB_SEL_STAT
  } kpb_sel_t;

endpackage : kpb_pkg
